// ---- src/drive_monitor_fault_history.sv ----
`timescale 1ns/1ps
`default_nettype none

module drive_monitor_fault_history #(
    parameter int TIME_STEP_CYCLES = drive_monitor_pkg::TIME_STEP_CYCLES
) (
    input  wire logic                           aclk,
    input  wire logic                           aresetn,
    input  wire logic [7:0]                     s_axi_awaddr,
    input  wire logic [2:0]                     s_axi_awprot,
    input  wire logic                           s_axi_awvalid,
    output var  logic                           s_axi_awready,
    input  wire logic [31:0]                    s_axi_wdata,
    input  wire logic [3:0]                     s_axi_wstrb,
    input  wire logic                           s_axi_wvalid,
    output var  logic                           s_axi_wready,
    output var  logic [1:0]                     s_axi_bresp,
    output var  logic                           s_axi_bvalid,
    input  wire logic                           s_axi_bready,
    input  wire logic [7:0]                     s_axi_araddr,
    input  wire logic [2:0]                     s_axi_arprot,
    input  wire logic                           s_axi_arvalid,
    output var  logic                           s_axi_arready,
    output var  logic [31:0]                    s_axi_rdata,
    output var  logic [1:0]                     s_axi_rresp,
    output var  logic                           s_axi_rvalid,
    input  wire logic                           s_axi_rready,
    input  wire drive_monitor_pkg::ref_step_t   ref_step,
    input  wire logic                           fb_step,
    input  wire logic [15:0]                    fb_units,
    input  wire drive_monitor_pkg::live_meas_t  live_meas,
    input  wire logic                           fault_event,
    input  wire logic [15:0]                    fault_code,
    output var  logic                           irq
);

    localparam int HD = drive_monitor_pkg::HIST_DEPTH;

    // Counters
    logic [31:0] ref_count_reg;
    logic [31:0] ref_enc_sum_reg;
    logic [31:0] fb_count_reg;
    logic [31:0] deviation_reg;
    logic [31:0] time_total_reg;
    logic [31:0] tick_cnt_reg;
    logic        tick;
    logic        time_wrap;

    // Live measurements and history
    drive_monitor_pkg::live_meas_t  meas_reg;
    drive_monitor_pkg::hist_entry_t hist_reg [HD];
    drive_monitor_pkg::hist_entry_t sel_entry_reg;
    drive_monitor_pkg::hist_entry_t sel_entry_next;
    drive_monitor_pkg::hist_entry_t new_entry;

    // Software registers
    logic [15:0]                             hist_sel_reg;
    logic [drive_monitor_pkg::IRQ_WIDTH-1:0] irq_status_reg;
    logic [drive_monitor_pkg::IRQ_WIDTH-1:0] irq_mask_reg;
    logic [drive_monitor_pkg::IRQ_WIDTH-1:0] irq_set;
    logic [drive_monitor_pkg::IRQ_WIDTH-1:0] irq_clr;

    // Bus state
    logic        aw_held_reg;
    logic        w_held_reg;
    logic [7:0]  aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;

    // Sign-extends a 16-bit step to the counter width
    function automatic logic [31:0] sext16(input logic [15:0] v);
        sext16 = {{16{v[15]}}, v};
    endfunction

    // Applies byte enables to a 32-bit register image
    function automatic logic [31:0] merge_bytes(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  strb
    );
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        merge_bytes = r;
    endfunction

    // Read decode shared by data and response
    function automatic logic [32:0] read_decode(
        input logic [7:0]                     a,
        input logic [31:0]                    c_ref,
        input logic [31:0]                    c_dev,
        input logic [31:0]                    c_fb,
        input logic [31:0]                    c_time,
        input drive_monitor_pkg::live_meas_t  m,
        input logic [15:0]                    sel,
        input drive_monitor_pkg::hist_entry_t e,
        input logic [1:0]                     st,
        input logic [1:0]                     mk
    );
        logic [32:0] r;
        r = {1'b1, 32'h0000_0000};
        case (a)
            drive_monitor_pkg::OFS_INPUT_REFERENCE_COUNT:    r = {1'b0, c_ref};
            drive_monitor_pkg::OFS_POSITION_DEVIATION_COUNT: r = {1'b0, c_dev};
            drive_monitor_pkg::OFS_FEEDBACK_PULSE_COUNT:     r = {1'b0, c_fb};
            drive_monitor_pkg::OFS_POWERED_TIME_TOTAL:       r = {1'b0, c_time};
            drive_monitor_pkg::OFS_PHASE_CURRENT_RMS:        r = {17'h00000, m.current_rms};
            drive_monitor_pkg::OFS_LINK_VOLTAGE:             r = {17'h00000, m.link_voltage};
            drive_monitor_pkg::OFS_POWER_STAGE_TEMPERATURE:  r = {17'h00000, m.temperature};
            drive_monitor_pkg::OFS_HISTORY_SELECTOR:         r = {17'h00000, sel};
            drive_monitor_pkg::OFS_SELECTED_FAULT_CODE:      r = {17'h00000, e.code};
            drive_monitor_pkg::OFS_FAULT_TIME_SNAPSHOT:      r = {1'b0, e.time_stamp};
            drive_monitor_pkg::OFS_FAULT_SPEED_SNAPSHOT:     r = {17'h00000, e.speed};
            drive_monitor_pkg::OFS_FAULT_PHASE_A_CURRENT:    r = {17'h00000, e.phase_a_current};
            drive_monitor_pkg::OFS_FAULT_PHASE_B_CURRENT:    r = {17'h00000, e.phase_b_current};
            drive_monitor_pkg::OFS_FAULT_LINK_VOLTAGE:       r = {17'h00000, e.link_voltage};
            drive_monitor_pkg::OFS_IRQ_STATUS:               r = {31'h0000_0000, st};
            drive_monitor_pkg::OFS_IRQ_MASK:                 r = {31'h0000_0000, mk};
            default:                                         r = {1'b1, 32'h0000_0000};
        endcase
        read_decode = r;
    endfunction

    // Time base and counters
    assign tick      = (tick_cnt_reg == 32'(TIME_STEP_CYCLES - 1));
    assign time_wrap = tick && (time_total_reg == 32'hffff_ffff);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tick_cnt_reg   <= 32'h0000_0000;
            time_total_reg <= 32'h0000_0000;
        end
        else
        begin
            tick_cnt_reg   <= tick ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
            time_total_reg <= tick ? time_total_reg + 32'h0000_0001 : time_total_reg;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ref_count_reg   <= 32'h0000_0000;
            ref_enc_sum_reg <= 32'h0000_0000;
            fb_count_reg    <= 32'h0000_0000;
        end
        else
        begin
            if (ref_step.step)
            begin
                ref_count_reg   <= ref_count_reg + sext16(ref_step.ref_units);
                ref_enc_sum_reg <= ref_enc_sum_reg + sext16(ref_step.enc_units);
            end
            if (fb_step)
            begin
                fb_count_reg <= fb_count_reg + sext16(fb_units);
            end
        end
    end

    // Deviation is kept registered so it reads coherently
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            deviation_reg <= 32'h0000_0000;
        end
        else
        begin
            deviation_reg <= ref_enc_sum_reg - fb_count_reg;
        end
    end

    // Live measurement capture
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meas_reg <= '0;
        end
        else
        begin
            meas_reg <= live_meas;
        end
    end

    // Fault history
    assign new_entry = '{valid:           1'b1,
                         code:            fault_code,
                         time_stamp:      time_total_reg,
                         speed:           meas_reg.speed,
                         phase_a_current: meas_reg.phase_a_current,
                         phase_b_current: meas_reg.phase_b_current,
                         link_voltage:    meas_reg.link_voltage};

    generate
        for (genvar i = 0; i < HD; i++)
        begin : g_hist
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    hist_reg[i] <= '0;
                end
                else if (fault_event)
                begin
                    hist_reg[i] <= (i == 0) ? new_entry : hist_reg[(i == 0) ? 0 : i - 1];
                end
            end
        end
    endgenerate

    // Empty entries read as no fault with zero snapshot
    always_comb
    begin
        sel_entry_next = '0;
        sel_entry_next.code = drive_monitor_pkg::NO_FAULT_CODE;
        if (hist_sel_reg <= drive_monitor_pkg::HIST_SEL_LAST)
        begin
            if (hist_reg[hist_sel_reg[3:0]].valid)
            begin
                sel_entry_next = hist_reg[hist_sel_reg[3:0]];
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sel_entry_reg <= '0;
        end
        else
        begin
            sel_entry_reg <= sel_entry_next;
        end
    end

    // Write channel
    logic        wr_go;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        wr_sel;
    logic        wr_stat;
    logic        wr_mask;
    logic        wr_hit;
    logic [31:0] sel_merged;
    logic [31:0] stat_bits;
    logic [31:0] mask_merged;
    logic [32:0] wr_word;

    assign wr_addr     = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
    assign wr_data     = w_held_reg ? w_data_reg : s_axi_wdata;
    assign wr_strb     = w_held_reg ? w_strb_reg : s_axi_wstrb;
    assign wr_go       = (aw_held_reg || (s_axi_awvalid && s_axi_awready))
                      && (w_held_reg || (s_axi_wvalid && s_axi_wready));
    assign wr_sel      = wr_go && (wr_addr == drive_monitor_pkg::OFS_HISTORY_SELECTOR);
    assign wr_stat     = wr_go && (wr_addr == drive_monitor_pkg::OFS_IRQ_STATUS);
    assign wr_mask     = wr_go && (wr_addr == drive_monitor_pkg::OFS_IRQ_MASK);
    assign wr_word     = read_decode(wr_addr, ref_count_reg, deviation_reg, fb_count_reg, time_total_reg,
                                     meas_reg, hist_sel_reg, sel_entry_reg, irq_status_reg, irq_mask_reg);
    assign wr_hit      = !wr_word[32];
    assign sel_merged  = merge_bytes({16'h0000, hist_sel_reg}, wr_data, wr_strb);
    assign stat_bits   = merge_bytes(32'h0000_0000, wr_data, wr_strb);
    assign mask_merged = merge_bytes({30'h0000_0000, irq_mask_reg}, wr_data, wr_strb);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= drive_monitor_pkg::RESP_OKAY;
            aw_held_reg   <= 1'b0;
            w_held_reg    <= 1'b0;
            aw_addr_reg   <= 8'h00;
            w_data_reg    <= 32'h0000_0000;
            w_strb_reg    <= 4'h0;
        end
        else
        begin
            s_axi_awready <= !s_axi_bvalid && !wr_go && !aw_held_reg && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !s_axi_bvalid && !wr_go && !w_held_reg && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? drive_monitor_pkg::RESP_OKAY : drive_monitor_pkg::RESP_DECERR;
            end
            else if (s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Software registers and interrupt
    assign irq_set = {time_wrap, fault_event};
    assign irq_clr = wr_stat ? stat_bits[drive_monitor_pkg::IRQ_WIDTH-1:0] : 2'h0;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            hist_sel_reg   <= drive_monitor_pkg::HIST_SEL_RESET;
            irq_mask_reg   <= drive_monitor_pkg::IRQ_MASK_RESET;
            irq_status_reg <= 2'h0;
            irq            <= 1'b0;
        end
        else
        begin
            if (wr_sel)
            begin
                hist_sel_reg <= sel_merged[15:0];
            end
            if (wr_mask)
            begin
                irq_mask_reg <= mask_merged[drive_monitor_pkg::IRQ_WIDTH-1:0];
            end
            irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
            irq            <= |(((irq_status_reg & ~irq_clr) | irq_set) & irq_mask_reg);
        end
    end

    // Read channel
    logic [32:0] rd_word;

    assign rd_word = read_decode(s_axi_araddr, ref_count_reg, deviation_reg, fb_count_reg, time_total_reg,
                                 meas_reg, hist_sel_reg, sel_entry_reg, irq_status_reg, irq_mask_reg);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= drive_monitor_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word[31:0];
                s_axi_rresp  <= rd_word[32] ? drive_monitor_pkg::RESP_DECERR : drive_monitor_pkg::RESP_OKAY;
            end
            else if (s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// ---- common/drive_monitor_pkg.sv ----
package drive_monitor_pkg;

    // Byte offsets of the register map
    localparam logic [7:0] OFS_INPUT_REFERENCE_COUNT    = 8'h00;
    localparam logic [7:0] OFS_POSITION_DEVIATION_COUNT = 8'h04;
    localparam logic [7:0] OFS_FEEDBACK_PULSE_COUNT     = 8'h08;
    localparam logic [7:0] OFS_POWERED_TIME_TOTAL       = 8'h0c;
    localparam logic [7:0] OFS_PHASE_CURRENT_RMS        = 8'h10;
    localparam logic [7:0] OFS_LINK_VOLTAGE             = 8'h14;
    localparam logic [7:0] OFS_POWER_STAGE_TEMPERATURE  = 8'h18;
    localparam logic [7:0] OFS_HISTORY_SELECTOR         = 8'h1c;
    localparam logic [7:0] OFS_SELECTED_FAULT_CODE      = 8'h20;
    localparam logic [7:0] OFS_FAULT_TIME_SNAPSHOT      = 8'h24;
    localparam logic [7:0] OFS_FAULT_SPEED_SNAPSHOT     = 8'h28;
    localparam logic [7:0] OFS_FAULT_PHASE_A_CURRENT    = 8'h2c;
    localparam logic [7:0] OFS_FAULT_PHASE_B_CURRENT    = 8'h30;
    localparam logic [7:0] OFS_FAULT_LINK_VOLTAGE       = 8'h34;
    localparam logic [7:0] OFS_IRQ_STATUS               = 8'h38;
    localparam logic [7:0] OFS_IRQ_MASK                 = 8'h3c;

    // Interrupt status and mask bit positions
    localparam int IRQ_BIT_FAULT     = 0;
    localparam int IRQ_BIT_TIME_WRAP = 1;
    localparam int IRQ_WIDTH         = 2;

    // History layout
    localparam int HIST_DEPTH = 10;
    localparam logic [15:0] HIST_SEL_LAST = 16'h0009;
    localparam logic [15:0] NO_FAULT_CODE = 16'h0000;

    // Reset values
    localparam logic [15:0] HIST_SEL_RESET = 16'h0000;
    localparam logic [IRQ_WIDTH-1:0] IRQ_MASK_RESET = 2'h0;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // Time base: one power-on time step per tenth of a second
    localparam longint CLK_PERIOD_NS = 100;
    localparam longint TIME_STEP_NS  = 100_000_000;
    localparam int     TIME_STEP_CYCLES = int'(TIME_STEP_NS / CLK_PERIOD_NS);

    typedef struct packed {
        logic [15:0] current_rms;
        logic [15:0] link_voltage;
        logic [15:0] temperature;
        logic [15:0] speed;
        logic [15:0] phase_a_current;
        logic [15:0] phase_b_current;
    } live_meas_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] code;
        logic [31:0] time_stamp;
        logic [15:0] speed;
        logic [15:0] phase_a_current;
        logic [15:0] phase_b_current;
        logic [15:0] link_voltage;
    } hist_entry_t;

    typedef struct packed {
        logic        step;
        logic [15:0] ref_units;
        logic [15:0] enc_units;
    } ref_step_t;

endpackage

// ---- sim/drive_monitor_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module drive_monitor_asserts (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("write not answered");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while pending");
    a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while pending");
    a_read_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h40
        |=> s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_write_unmapped: assert property (s_axi_awvalid && s_axi_awready && s_axi_awaddr >= 8'h40
        ##1 s_axi_bvalid |-> s_axi_bresp == 2'h3)
        else $error("unmapped write not refused");
endmodule
bind drive_monitor_fault_history drive_monitor_asserts chk_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

// ---- sim/tb_drive_monitor_fault_history.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_drive_monitor_fault_history;
    logic                          aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic                          awready, wready, bvalid, arready, rvalid, fb_step, fault_event, irq;
    logic [7:0]                    awaddr, araddr;
    logic [31:0]                   wdata, rdata, d, t1, sum_ref, sum_enc, sum_fb;
    logic [1:0]                    bresp, rresp, r;
    logic [15:0]                   fb_units, fault_code;
    logic [15:0]                   cd [11], sp [11], pa [11], pb [11], lv [11];
    drive_monitor_pkg::ref_step_t  ref_step, rs;
    drive_monitor_pkg::live_meas_t live_meas;
    int                            failures, samples_checked;

    drive_monitor_fault_history #(.TIME_STEP_CYCLES(10)) uut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .ref_step(ref_step), .fb_step(fb_step), .fb_units(fb_units), .live_meas(live_meas),
        .fault_event(fault_event), .fault_code(fault_code), .irq(irq));

    initial
    begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    function automatic logic [31:0] sx(input logic [15:0] v);
        return {{16{v[15]}}, v};
    endfunction

    function automatic logic [31:0] hx(input int s, input logic [15:0] v [11]);
        return (s > 9) ? 32'h0 : {16'h0, v[10-s]};
    endfunction

    task end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e)
        begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask

    task tmo;
        failures++;
        $display("[ERR] %0t handshake timed out", $time);
        end_of_test();
    endtask

    task wr(input logic [7:0] a, input logic [31:0] v);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        if (n == 50) tmo();
        r = bresp;
        bready <= 1'b0;
    endtask

    task rd(input logic [7:0] a);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        if (n == 50) tmo();
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task rc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(d, e);
    endtask

    task fault_pulse(input logic [15:0] c, input int k);
        @(posedge aclk);
        live_meas <= {$urandom, $urandom, $urandom};
        fault_code <= c;
        repeat (3) @(posedge aclk);
        fault_event <= 1'b1;
        cd[k] = fault_code;
        sp[k] = live_meas.speed;
        pa[k] = live_meas.phase_a_current;
        pb[k] = live_meas.phase_b_current;
        lv[k] = live_meas.link_voltage;
        @(posedge aclk);
        fault_event <= 1'b0;
    endtask

    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, fb_step, fault_event} = '0;
        {awaddr, araddr, wdata, fb_units, fault_code, ref_step, live_meas} = '0;
        {failures, samples_checked, sum_ref, sum_enc, sum_fb} = '0;
        void'($urandom(63));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rc(drive_monitor_pkg::OFS_HISTORY_SELECTOR, 32'h0);
        rc(drive_monitor_pkg::OFS_SELECTED_FAULT_CODE, 32'h0);
        rc(drive_monitor_pkg::OFS_FAULT_TIME_SNAPSHOT, 32'h0);
        rc(drive_monitor_pkg::OFS_IRQ_MASK, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 40; i++)
        begin
            @(posedge aclk);
            rs = (i == 0) ? {1'b1, 16'h8000, 16'h8000} : {1'($urandom), 16'($urandom), 16'($urandom)};
            ref_step <= rs;
            fb_step <= (i == 0) ? 1'b1 : 1'($urandom);
            fb_units <= (i == 0) ? 16'h7fff : 16'($urandom);
            @(negedge aclk);
            if (rs.step) sum_ref += sx(rs.ref_units);
            if (rs.step) sum_enc += sx(rs.enc_units);
            if (fb_step) sum_fb += sx(fb_units);
        end
        @(posedge aclk);
        ref_step <= '0;
        fb_step <= 1'b0;
        repeat (3) @(posedge aclk);
        rc(drive_monitor_pkg::OFS_INPUT_REFERENCE_COUNT, sum_ref);
        rc(drive_monitor_pkg::OFS_FEEDBACK_PULSE_COUNT, sum_fb);
        rc(drive_monitor_pkg::OFS_POSITION_DEVIATION_COUNT, sum_enc - sum_fb);
        wr(drive_monitor_pkg::OFS_INPUT_REFERENCE_COUNT, 32'hffff_ffff);
        chk({30'h0, r}, {30'h0, drive_monitor_pkg::RESP_OKAY});
        rc(drive_monitor_pkg::OFS_INPUT_REFERENCE_COUNT, sum_ref);
        $display("test counters done");
        @(posedge aclk);
        live_meas <= {$urandom, $urandom, $urandom};
        repeat (3) @(posedge aclk);
        rc(drive_monitor_pkg::OFS_PHASE_CURRENT_RMS, {16'h0, live_meas.current_rms});
        rc(drive_monitor_pkg::OFS_LINK_VOLTAGE, {16'h0, live_meas.link_voltage});
        rc(drive_monitor_pkg::OFS_POWER_STAGE_TEMPERATURE, {16'h0, live_meas.temperature});
        rd(drive_monitor_pkg::OFS_POWERED_TIME_TOTAL);
        t1 = d;
        repeat (100) @(posedge aclk);
        rd(drive_monitor_pkg::OFS_POWERED_TIME_TOTAL);
        chk({31'h0, (d - t1 >= 32'd10) && (d - t1 <= 32'd11)}, 32'h1);
        $display("test live values done");
        wr(drive_monitor_pkg::OFS_IRQ_MASK, 32'h1);
        wr(drive_monitor_pkg::OFS_IRQ_STATUS, 32'h3);
        for (int k = 0; k < 11; k++)
            fault_pulse((k == 0) ? 16'hffff : 16'($urandom), k);
        repeat (3) @(posedge aclk);
        chk({31'h0, irq}, 32'h1);
        rc(drive_monitor_pkg::OFS_IRQ_STATUS, 32'h1);
        wr(drive_monitor_pkg::OFS_IRQ_STATUS, 32'h1);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        for (int s = 0; s < 11; s++)
        begin
            wr(drive_monitor_pkg::OFS_HISTORY_SELECTOR, s);
            rc(drive_monitor_pkg::OFS_HISTORY_SELECTOR, s);
            rc(drive_monitor_pkg::OFS_SELECTED_FAULT_CODE, hx(s, cd));
            rc(drive_monitor_pkg::OFS_FAULT_SPEED_SNAPSHOT, hx(s, sp));
            rc(drive_monitor_pkg::OFS_FAULT_PHASE_A_CURRENT, hx(s, pa));
            rc(drive_monitor_pkg::OFS_FAULT_PHASE_B_CURRENT, hx(s, pb));
            rc(drive_monitor_pkg::OFS_FAULT_LINK_VOLTAGE, hx(s, lv));
            rd(drive_monitor_pkg::OFS_FAULT_TIME_SNAPSHOT);
            if (s == 0) t1 = d + 32'h1;
            chk({31'h0, (s < 10) ? ((t1 - d <= 32'h1) && (d != 32'h0)) : (d == 32'h0)}, 32'h1);
            t1 = d;
        end
        $display("test history done");
        wr(drive_monitor_pkg::OFS_IRQ_MASK, 32'h0);
        fault_pulse(16'h0123, 0);
        repeat (3) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        rc(drive_monitor_pkg::OFS_IRQ_STATUS, 32'h1);
        rd(8'h44);
        chk({30'h0, r}, {30'h0, drive_monitor_pkg::RESP_DECERR});
        chk(d, 32'h0);
        wr(8'h40, 32'h1);
        chk({30'h0, r}, {30'h0, drive_monitor_pkg::RESP_DECERR});
        $display("test irq and decode done");
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rc(drive_monitor_pkg::OFS_SELECTED_FAULT_CODE, 32'h0);
        rc(drive_monitor_pkg::OFS_INPUT_REFERENCE_COUNT, 32'h0);
        $display("test second reset done");
        end_of_test();
    end
endmodule
`default_nettype wire
